// file: core/ter_regs.svh
// Register offsets, field positions, reset values and timing counts of the timing receiver.
`ifndef TER_REGS_SVH
`define TER_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TER_OFF_STATUS 8'h00
`define TER_OFF_CODES 8'h04
`define TER_OFF_XCTRL 8'h08
`define TER_OFF_TRIGSRC 8'h0C
`define TER_OFF_ENABLE 8'h10
`define TER_OFF_MINFRM 8'h20
`define TER_OFF_MINTIME 8'h24
`define TER_OFF_SOSCTL 8'h40
`define TER_OFF_EVCOUNT 8'h48
`define TER_OFF_EVTIME 8'h4C
`define TER_OFF_SEGTIME 8'h50

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TER_ST_LOCK 0
`define TER_ST_RSTDONE 1
`define TER_ST_LOS 8
`define TER_ST_RSTDONE2 9
`define TER_XC_RESET 0
`define TER_TRIG_SEL 24
`define TER_SOS_EN 0
`define TER_SOS_CODE_LSB 8
`define TER_BYTE_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TER_RST_MINFRM 32'h00000064
`define TER_RST_MINTIME 32'h0015CA20
`define TER_RST_SOS_CODE 8'h20

// ----------------------------------------------------------------
// Link symbols and timing
// ----------------------------------------------------------------
`define TER_COMMA 8'hBC
`define TER_FRAME_K 8'h1C
`define TER_NULL_CODE 8'h00
`define TER_SEG_LEN 5'h10
`define TER_LOS_WORDS 8'h40
`define TER_WIN_MS 10
`define TER_LINK_KHZ 142800
`define TER_WIN_CYC (`TER_WIN_MS * `TER_LINK_KHZ)

`endif

// file: core/ter_pkg.sv
// Types shared by the timing receiver modules.
package ter_pkg;

  typedef logic [7:0] ter_byte_t;
  typedef logic [31:0] ter_word_t;

  typedef struct packed {
    logic lclk_d;
    logic [8:0] prev_hi;
    logic slip;
    logic [7:0] los_cnt;
    logic in_frame;
    logic [4:0] frame_idx;
    logic [6:0] seg_id;
    ter_byte_t csum;
    ter_word_t good_frames;
    ter_word_t since_frame;
    ter_word_t led0_cnt;
    ter_word_t ts;
    ter_word_t ev_count;
    ter_word_t ev_ts;
    ter_word_t seg_ts;
    logic ext_d;
    logic ext_pend;
    ter_word_t codes;
    logic xreset;
    logic trig_sel;
    ter_word_t ena;
    ter_word_t min_frames;
    ter_word_t min_time;
    logic sos_en;
    ter_byte_t sos_code;
    logic ram_we;
    logic [10:0] ram_addr;
    ter_byte_t ram_data;
    ter_byte_t dbus;
    logic [3:0] events;
    logic irq;
    logic sos;
    logic [1:0] leds;
    logic [15:0] tx_data;
    logic [1:0] tx_k;
    logic rec_clk;
    logic pready;
    ter_word_t prdata;
    logic pslverr;
  } ter_state_t;

endpackage

// file: core/ter_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module ter_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // ter_sync

// file: core/ter_seg_ram.sv
// Dual-clock segment data memory: write port on the link side, read port on the user clock.
`timescale 1ns/1ps
module ter_seg_ram (
  input wire logic wr_clk_in,
  input wire logic wr_en_in,
  input wire logic [10:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_clk_in,
  input wire logic [10:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [0:2047];

  always_ff @(posedge wr_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // The read side shares no signal with the writer, so it can run on any clock.
  always_ff @(posedge rd_clk_in) begin
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // ter_seg_ram

// file: core/ter_top.sv
// Timing event receiver: link word alignment, event and bus decoding, segment buffer, APB.
//
// Functional notes
// - Recover the link clock with fixed phase; no elastic buffering of received words.
// - Find commas and align received words in own logic.
// - Everything derived from received data changes only on recovered clock edges.
// - Segment buffer is dual-port memory; read port runs on user clock.
// - Received parallel words are looped back to the transmit path.
// - Four user event codes, changeable at run time without restart.
// - Distributed bus output updated every recovered clock cycle outside segment frames.
// - Matched user event gives one recovered-clock-cycle pulse on its bit.
// - Event pulses suppressed unless at least 100 good segment frames counted and one arrived within 10 ms.
// - Interrupt output asserted when a user event fired.
// - Indicator 0 on while event 0 pulsed within last 10 ms.
// - Indicator 1 shows loss of link synchronisation.
// - Register interface runs on the host bus clock.
// - Reception starts by itself; only the event table needs setting.
// - Recorder counts events and stamps arrival time since start-of-sequence.
// - Recorder stamps each segment arrival time since start-of-sequence.
// - Four 8-bit event codes, event 0 in lowest byte.
// - Each event decodes only with its enable bit at 0, 8, 16, 24.
// - Select bit chooses link events or external trigger input.
// - Start-of-sequence code 8-bit, default 0x20, with its own enable.
`timescale 1ns/1ps
`include "ter_regs.svh"
module ter_top #(
  parameter int unsigned WIN_CYC = `TER_WIN_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic LINK_CLK_IN,
  input wire logic [15:0] LINK_DATA_IN,
  input wire logic [1:0] LINK_CHARISK_IN,
  input wire logic XCVR_PLL_LOCK_IN,
  input wire logic XCVR_RESET_DONE_IN,
  input wire logic EXTERNAL_TRIGGER_IN,
  output logic XCVR_RESET_OUT,
  output logic [15:0] TX_DATA_OUT,
  output logic [1:0] TX_CHARISK_OUT,
  output logic RECOVERED_CLOCK_NET_OUT,
  output logic [7:0] DBUS_OUT,
  output logic [3:0] USER_EVENTS_OUT,
  output logic SOS_EVENT_OUT,
  output logic IRQ_OUT,
  output logic [1:0] LINK_INDICATORS_OUT,
  input wire logic USER_CLK_IN,
  input wire logic [10:0] SEG_RADDR_IN,
  output logic [7:0] SEG_RDATA_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic ter_pkg::ter_byte_t code_of(input ter_pkg::ter_word_t w, input int i);
    code_of = w[i*`TER_BYTE_W +: `TER_BYTE_W];
  endfunction

  function automatic ter_pkg::ter_word_t sat_inc(input ter_pkg::ter_word_t v);
    sat_inc = (v == '1) ? v : v + 32'h00000001;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [21:0] sy;
  ter_sync #(.W(22)) u_sync (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .async_in({EXTERNAL_TRIGGER_IN, XCVR_RESET_DONE_IN, XCVR_PLL_LOCK_IN,
               LINK_CHARISK_IN, LINK_DATA_IN, LINK_CLK_IN}),
    .sync_out(sy)
  );

  logic sy_clk;
  logic [15:0] sy_data;
  logic [1:0] sy_k;
  logic sy_lock;
  logic sy_rstdone;
  logic sy_ext;
  assign sy_clk = sy[0];
  assign sy_data = sy[16:1];
  assign sy_k = sy[18:17];
  assign sy_lock = sy[19];
  assign sy_rstdone = sy[20];
  assign sy_ext = sy[21];

  ter_pkg::ter_state_t st;
  ter_pkg::ter_state_t next_st;

  ter_seg_ram u_ram (
    .wr_clk_in(CLOCK_IN),
    .wr_en_in(st.ram_we),
    .wr_addr_in(st.ram_addr),
    .wr_data_in(st.ram_data),
    .rd_clk_in(USER_CLK_IN),
    .rd_addr_in(SEG_RADDR_IN),
    .rd_data_out(SEG_RDATA_OUT)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic strobe;
  logic [15:0] word;
  logic [1:0] wk;
  ter_pkg::ter_byte_t code;
  logic is_code;
  logic los;
  logic trig_ok;
  logic [3:0] hit;
  logic apb_setup;
  logic apb_write;
  ter_pkg::ter_word_t rdata;
  logic mapped;

  always_comb begin
    next_st = st;
    next_st.ram_we = 1'b0;
    next_st.lclk_d = sy_clk;
    // Data is launched on the rising link edge, so it is taken at the falling one.
    strobe = st.lclk_d & ~sy_clk;
    word = st.slip ? {sy_data[7:0], st.prev_hi[7:0]} : sy_data;
    wk = st.slip ? {sy_k[0], st.prev_hi[8]} : sy_k;
    code = word[7:0];
    is_code = ~wk[0] && (code != `TER_NULL_CODE);
    los = (st.los_cnt >= `TER_LOS_WORDS);
    trig_ok = (st.good_frames >= st.min_frames) && (st.since_frame < st.min_time);
    hit = '0;

    next_st.ext_d = sy_ext;

    if (strobe) begin
      next_st.rec_clk = 1'b0;
      next_st.prev_hi = {sy_k[1], sy_data[15:8]};
      next_st.tx_data = sy_data;
      next_st.tx_k = sy_k;
      // Comma search is continuous, so reception starts without software help.
      if (wk[0] && code == `TER_COMMA) begin
        next_st.los_cnt = '0;
      end else if (sy_k[1] && sy_data[15:8] == `TER_COMMA && !st.slip) begin
        next_st.slip = 1'b1;
        next_st.los_cnt = '0;
      end else if (sy_k[0] && sy_data[7:0] == `TER_COMMA && st.slip) begin
        next_st.slip = 1'b0;
        next_st.los_cnt = '0;
      end else if (!los) begin
        next_st.los_cnt = st.los_cnt + 8'h01;
      end

      for (int i = 0; i < 4; i++) begin
        if (st.ena[i*`TER_BYTE_W] && trig_ok) begin
          if (st.trig_sel) begin
            hit[i] = st.ext_pend;
          end else begin
            hit[i] = is_code && code == code_of(st.codes, i);
          end
        end
      end
      next_st.ext_pend = 1'b0;
      next_st.events = hit;
      next_st.irq = |hit;
      next_st.led0_cnt = hit[0] ? '0 : sat_inc(st.led0_cnt);
      next_st.leds = {los, hit[0] || (st.led0_cnt < WIN_CYC)};

      next_st.sos = 1'b0;
      next_st.ts = sat_inc(st.ts);
      if (is_code) begin
        if (st.sos_en && code == st.sos_code) begin
          next_st.sos = 1'b1;
          next_st.ts = '0;
          next_st.ev_count = '0;
        end
        next_st.ev_count = (st.sos_en && code == st.sos_code) ? 32'h00000001 :
                           sat_inc(st.ev_count);
        next_st.ev_ts = (st.sos_en && code == st.sos_code) ? '0 : st.ts;
      end

      next_st.since_frame = sat_inc(st.since_frame);
      if (wk[0] && code == `TER_FRAME_K) begin
        next_st.in_frame = 1'b1;
        next_st.frame_idx = '0;
        next_st.seg_id = word[14:8];
        next_st.csum = '0;
        next_st.seg_ts = st.ts;
      end else if (st.in_frame) begin
        if (st.frame_idx < `TER_SEG_LEN) begin
          next_st.ram_we = 1'b1;
          next_st.ram_addr = {st.seg_id, st.frame_idx[3:0]};
          next_st.ram_data = word[15:8];
          next_st.csum = st.csum + word[15:8];
          next_st.frame_idx = st.frame_idx + 5'h01;
        end else begin
          next_st.in_frame = 1'b0;
          if (word[15:8] == st.csum) begin
            next_st.good_frames = sat_inc(st.good_frames);
            next_st.since_frame = '0;
          end
        end
      end else begin
        next_st.dbus = word[15:8];
      end
      if (los) begin
        next_st.good_frames = '0;
      end
    end else if (st.lclk_d == 1'b0 && sy_clk == 1'b1) begin
      next_st.rec_clk = 1'b1;
    end

    // A trigger edge in the strobe cycle is kept for the next word rather than lost.
    if (sy_ext & ~st.ext_d) begin
      next_st.ext_pend = 1'b1;
    end

    // APB slave with no wait state: answer is prepared in the setup cycle.
    apb_setup = PSEL_IN & ~PENABLE_IN;
    apb_write = PSEL_IN & PENABLE_IN & st.pready & PWRITE_IN;
    mapped = 1'b1;
    rdata = '0;
    unique case (PADDR_IN)
      `TER_OFF_STATUS: begin
        rdata[`TER_ST_LOCK] = sy_lock;
        rdata[`TER_ST_RSTDONE] = sy_rstdone;
        rdata[`TER_ST_LOS] = los;
        rdata[`TER_ST_RSTDONE2] = sy_rstdone;
      end
      `TER_OFF_CODES: rdata = st.codes;
      `TER_OFF_XCTRL: rdata[`TER_XC_RESET] = st.xreset;
      `TER_OFF_TRIGSRC: rdata[`TER_TRIG_SEL] = st.trig_sel;
      `TER_OFF_ENABLE: rdata = st.ena;
      `TER_OFF_MINFRM: rdata = st.min_frames;
      `TER_OFF_MINTIME: rdata = st.min_time;
      `TER_OFF_SOSCTL: begin
        rdata[`TER_SOS_EN] = st.sos_en;
        rdata[`TER_SOS_CODE_LSB +: `TER_BYTE_W] = st.sos_code;
      end
      `TER_OFF_EVCOUNT: rdata = st.ev_count;
      `TER_OFF_EVTIME: rdata = st.ev_ts;
      `TER_OFF_SEGTIME: rdata = st.seg_ts;
      default: mapped = 1'b0;
    endcase
    next_st.pready = apb_setup;
    if (apb_setup) begin
      next_st.prdata = PWRITE_IN ? '0 : rdata;
      next_st.pslverr = ~mapped;
    end else begin
      next_st.prdata = '0;
      next_st.pslverr = 1'b0;
    end
    if (apb_write && mapped) begin
      unique case (PADDR_IN)
        `TER_OFF_CODES: next_st.codes = PWDATA_IN;
        `TER_OFF_XCTRL: next_st.xreset = PWDATA_IN[`TER_XC_RESET];
        `TER_OFF_TRIGSRC: next_st.trig_sel = PWDATA_IN[`TER_TRIG_SEL];
        `TER_OFF_ENABLE: next_st.ena = PWDATA_IN;
        `TER_OFF_MINFRM: next_st.min_frames = PWDATA_IN;
        `TER_OFF_MINTIME: next_st.min_time = PWDATA_IN;
        `TER_OFF_SOSCTL: begin
          next_st.sos_en = PWDATA_IN[`TER_SOS_EN];
          next_st.sos_code = PWDATA_IN[`TER_SOS_CODE_LSB +: `TER_BYTE_W];
        end
        default: next_st.codes = st.codes;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      st <= '0;
      st.since_frame <= '1;
      st.led0_cnt <= '1;
      st.los_cnt <= `TER_LOS_WORDS;
      st.min_frames <= `TER_RST_MINFRM;
      st.min_time <= `TER_RST_MINTIME;
      st.sos_code <= `TER_RST_SOS_CODE;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA_OUT = st.prdata;
  assign PREADY_OUT = st.pready;
  assign PSLVERR_OUT = st.pslverr;
  assign XCVR_RESET_OUT = st.xreset;
  assign TX_DATA_OUT = st.tx_data;
  assign TX_CHARISK_OUT = st.tx_k;
  assign RECOVERED_CLOCK_NET_OUT = st.rec_clk;
  assign DBUS_OUT = st.dbus;
  assign USER_EVENTS_OUT = st.events;
  assign SOS_EVENT_OUT = st.sos;
  assign IRQ_OUT = st.irq;
  assign LINK_INDICATORS_OUT = st.leds;

endmodule // ter_top

// file: bench/ter_top_asserts.sv
// Port-level concurrent checks of the timing receiver.
`timescale 1ns/1ps
module ter_top_asserts (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [15:0] TX_DATA_OUT,
  input wire logic [7:0] DBUS_OUT,
  input wire logic [3:0] USER_EVENTS_OUT,
  input wire logic SOS_EVENT_OUT,
  input wire logic IRQ_OUT,
  input wire logic [1:0] LINK_INDICATORS_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ------
  // Sequences
  // ------
  // One link word spans eight system cycles at the bench link rate.
  sequence one_word(s);
    s[*7] ##[1:2] !s;
  endsequence
  apb_answer_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h00000000)
    else $error("read data outside access");
  irq_or_a: assert property (IRQ_OUT == (|USER_EVENTS_OUT))
    else $error("interrupt differs from events");
  ev_pulse_a: assert property ($rose(|USER_EVENTS_OUT) |-> one_word(|USER_EVENTS_OUT))
    else $error("event pulse not one link cycle");
  sos_pulse_a: assert property ($rose(SOS_EVENT_OUT) |-> one_word(SOS_EVENT_OUT))
    else $error("sequence start pulse not one link cycle");
  led0_event_a: assert property ($rose(USER_EVENTS_OUT[0]) |-> LINK_INDICATORS_OUT[0])
    else $error("indicator 0 not lit by event 0");
  dbus_word_a: assert property ($changed(DBUS_OUT) |-> TX_DATA_OUT != $past(TX_DATA_OUT, 2))
    else $error("bus byte moved without a link word");
endmodule // ter_top_asserts

bind ter_top ter_top_asserts u_chk (
  .CLOCK_IN(CLOCK_IN),
  .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT),
  .TX_DATA_OUT(TX_DATA_OUT),
  .DBUS_OUT(DBUS_OUT),
  .USER_EVENTS_OUT(USER_EVENTS_OUT),
  .SOS_EVENT_OUT(SOS_EVENT_OUT),
  .IRQ_OUT(IRQ_OUT),
  .LINK_INDICATORS_OUT(LINK_INDICATORS_OUT)
);

// file: bench/ter_link_gen.sv
// Model of the upstream link word source.
`timescale 1ns/1ps
`include "ter_regs.svh"
module ter_link_gen (
  output logic link_clk_out,
  output logic [15:0] data_out,
  output logic [1:0] k_out
);
  logic [17:0] q [$];
  logic [7:0] dbus;
  logic no_comma;
  // A timing link never pauses, so its clock runs free between frames.
  initial begin
    link_clk_out = 1'b0;
    {k_out, data_out} = 18'h00000;
    dbus = 8'h00;
    no_comma = 1'b0;
    #3;
    forever #40 link_clk_out = ~link_clk_out;
  end
  // Idle words keep alignment with a comma in the low byte unless no_comma is set.
  always @(posedge link_clk_out) begin
    if (q.size() > 0)
      {k_out, data_out} <= q.pop_front();
    else if (no_comma)
      {k_out, data_out} <= {2'b00, dbus, `TER_NULL_CODE};
    else
      {k_out, data_out} <= {2'b01, dbus, `TER_COMMA};
  end
  task put(input logic [17:0] w);
    q.push_back(w);
  endtask
  task frame(input logic [6:0] seg, input logic [7:0] base);
    logic [7:0] sum;
    sum = 8'h00;
    put({2'b01, 1'b0, seg, `TER_FRAME_K});
    for (int i = 0; i < 16; i++) begin
      put({2'b00, base + 8'(i), `TER_NULL_CODE});
      sum = sum + base + 8'(i);
    end
    put({2'b00, sum, `TER_NULL_CODE});
  endtask
endmodule // ter_link_gen

// file: bench/tb_ter_top.sv
// Self-checking bench of the timing receiver.
`timescale 1ns/1ps
`include "ter_regs.svh"
module tb_ter_top;
  logic clk, rst_n, psel, pen, pwr, uclk, ext, pready, perr, err, lclk, sos, lock, xrst, rclk;
  logic [7:0] paddr, dbus_o, rdat;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ldata, txd;
  logic [1:0] lk, txk, leds;
  logic [3:0] ev, ev_prev;
  logic [10:0] raddr;
  int bad_count, compares, sos_cnt, rec_cnt;
  int ev_cnt [4];
  always #5 clk = ~clk;
  always #7 uclk = ~uclk;
  ter_link_gen i_gen (.link_clk_out(lclk), .data_out(ldata), .k_out(lk));
  ter_top #(.WIN_CYC(50)) i_dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(perr), .LINK_CLK_IN(lclk),
    .LINK_DATA_IN(ldata), .LINK_CHARISK_IN(lk), .XCVR_PLL_LOCK_IN(lock),
    .XCVR_RESET_DONE_IN(1'b1), .EXTERNAL_TRIGGER_IN(ext), .XCVR_RESET_OUT(xrst),
    .TX_DATA_OUT(txd), .TX_CHARISK_OUT(txk), .RECOVERED_CLOCK_NET_OUT(rclk),
    .DBUS_OUT(dbus_o), .USER_EVENTS_OUT(ev), .SOS_EVENT_OUT(sos), .IRQ_OUT(),
    .LINK_INDICATORS_OUT(leds), .USER_CLK_IN(uclk), .SEG_RADDR_IN(raddr),
    .SEG_RDATA_OUT(rdat));
  // ------
  // Pulse counters
  // ------
  always @(posedge clk) begin
    ev_prev <= ev;
    for (int i = 0; i < 4; i++)
      if (ev[i] && !ev_prev[i])
        ev_cnt[i]++;
    if ($rose(sos))
      sos_cnt++;
    if ($rose(rclk))
      rec_cnt++;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wait_words(input int n);
    repeat (n) @(posedge lclk);
    repeat (4) @(posedge clk);
  endtask
  task send_ev(input logic [7:0] code, input logic x, output logic [3:0] got);
    int b [4];
    b = ev_cnt;
    ext <= x;
    i_gen.put({2'b00, i_gen.dbus, code});
    wait_words(3);
    for (int i = 0; i < 4; i++)
      got[i] = ev_cnt[i] != b[i];
  endtask
  // ------
  // Scenarios
  // ------
  task t_regs;
    apb(1'b0, `TER_OFF_MINFRM, 32'h0);
    check(rd, `TER_RST_MINFRM);
    apb(1'b0, `TER_OFF_MINTIME, 32'h0);
    check(rd, `TER_RST_MINTIME);
    apb(1'b0, `TER_OFF_SOSCTL, 32'h0);
    check(rd, {16'h0, `TER_RST_SOS_CODE, 8'h00});
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    check(err, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `TER_OFF_XCTRL, 32'h1);
    @(posedge clk);
    check(xrst, 1'b1);
    apb(1'b0, `TER_OFF_XCTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, `TER_OFF_XCTRL, 32'h0);
    @(posedge clk);
    check(xrst, 1'b0);
    apb(1'b0, `TER_OFF_STATUS, 32'h0);
    check(rd, 32'h00000203);
    lock <= 1'b0;
    wait_words(1);
    apb(1'b0, `TER_OFF_STATUS, 32'h0);
    check(rd, 32'h00000202);
    lock <= 1'b1;
  endtask
  task t_events;
    logic [3:0] got;
    apb(1'b1, `TER_OFF_CODES, 32'h4D3C2B1A);
    apb(1'b1, `TER_OFF_ENABLE, 32'h01010101);
    send_ev(8'h1A, 1'b0, got);
    check(got, 4'h0);
    apb(1'b1, `TER_OFF_MINFRM, 32'h1);
    apb(1'b1, `TER_OFF_MINTIME, 32'd2000);
    i_gen.frame(7'h03, 8'h40);
    wait_words(20);
    for (int i = 0; i < 4; i++) begin
      send_ev(8'h1A + 8'(i * 17), 1'b0, got);
      check(got, 4'h1 << i);
    end
    check(leds[0], 1'b1);
    wait_words(60);
    check(leds[0], 1'b0);
    apb(1'b1, `TER_OFF_ENABLE, 32'h00010001);
    send_ev(8'h2B, 1'b0, got);
    check(got, 4'h0);
    apb(1'b1, `TER_OFF_CODES, 32'h4D3C2B77);
    send_ev(8'h77, 1'b0, got);
    check(got, 4'h1);
    apb(1'b1, `TER_OFF_MINTIME, 32'd20);
    send_ev(8'h77, 1'b0, got);
    check(got, 4'h0);
    apb(1'b1, `TER_OFF_MINTIME, 32'd2000);
  endtask
  task t_data;
    logic [3:0] got;
    int b0;
    i_gen.dbus = 8'hA5;
    wait_words(3);
    check(dbus_o, 8'hA5);
    check({txk, txd}, {2'b01, 8'hA5, `TER_COMMA});
    @(posedge lclk);
    b0 = rec_cnt;
    wait_words(4);
    @(posedge clk);
    check(rec_cnt - b0, 5);
    for (int i = 0; i < 16; i += 5) begin
      @(posedge uclk);
      raddr <= {7'h03, 4'(i)};
      @(posedge uclk);
      @(posedge uclk);
      check(rdat, 8'h40 + 8'(i));
    end
    apb(1'b1, `TER_OFF_SOSCTL, {16'h0, `TER_RST_SOS_CODE, 8'h01});
    b0 = sos_cnt;
    send_ev(`TER_RST_SOS_CODE, 1'b0, got);
    check(sos_cnt - b0, 1);
    send_ev(8'h2B, 1'b0, got);
    i_gen.frame(7'h04, 8'h10);
    wait_words(20);
    apb(1'b0, `TER_OFF_EVCOUNT, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, `TER_OFF_EVTIME, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, `TER_OFF_SEGTIME, 32'h0);
    check(rd, 32'h5);
    apb(1'b1, `TER_OFF_TRIGSRC, 32'h01000000);
    apb(1'b1, `TER_OFF_ENABLE, 32'h01010101);
    send_ev(8'h77, 1'b1, got);
    check(got, 4'hF);
    send_ev(8'h77, 1'b1, got);
    check(got, 4'h0);
    apb(1'b1, `TER_OFF_TRIGSRC, 32'h0);
    send_ev(8'h77, 1'b0, got);
    i_gen.no_comma = 1'b1;
    wait_words(70);
    check(leds[1], 1'b1);
    i_gen.no_comma = 1'b0;
    wait_words(3);
    check(leds[1], 1'b0);
    send_ev(8'h77, 1'b0, got);
    check(got, 4'h0);
  endtask
  task summarize;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {clk, uclk, psel, pen, pwr, ext, rst_n} = 7'h00;
    lock = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    raddr = 11'h000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_words(8);
    t_regs;
    t_events;
    t_data;
    summarize;
  end
  // The run needs well under this span; reaching it means a hang.
  initial begin
    #300000;
    bad_count++;
    summarize;
  end
endmodule // tb_ter_top
